// [src/sbla_pkg.sv]
// shared constants for the serial bootloader with baud detection
package sbla_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int BUS_REF_HZ = 2000000;
    // baud rates of the reference 2 MHz bus, used unscaled at our clock
    localparam int BAUD_FAST = 7812;
    localparam int BAUD_SLOW = 1200;
    // one bit time in clock cycles (no oversampling, one sample at bit centre)
    localparam int BIT_FAST = CLK_HZ / BAUD_FAST;
    localparam int BIT_SLOW = CLK_HZ / BAUD_SLOW;
    localparam int LOOP_CYCLES = 19;
    localparam int LOOP_ITER_FAST = 539;
    // 10,241 bus cycles at 2 MHz, converted to clock cycles
    localparam int TMO_BUS_FAST = LOOP_ITER_FAST * LOOP_CYCLES;
    localparam int TMO_FAST = (TMO_BUS_FAST * (CLK_HZ / BUS_REF_HZ));
    localparam int TMO_SLOW = TMO_FAST / BAUD_SLOW * BAUD_FAST;
    localparam int RAM_BYTES = 512;
    localparam int RAM_SMALL = 256;
    localparam logic [15:0] RAM_START = 16'h0000;
    localparam logic [15:0] EEPROM_START = 16'hb600;
    localparam logic [7:0] CHAR_ONES = 8'hff;
    localparam logic [7:0] CHAR_E0 = 8'he0;
    localparam logic [7:0] CHAR_C0 = 8'hc0;
    localparam logic [7:0] CHAR_ZERO = 8'h00;
    localparam int VEC_ADDR_BIT = 14;
    localparam int BREAK_BITS = 10;
endpackage : sbla_pkg

// [src/sbla_top.sv]
// mode logic, serial receiver/transmitter and download sequencer
// Functional notes
// - special mode forces A14 low on vectors
// - boot ROM enable resets 1 only in bootstrap
// - special test lets software set boot ROM
// - security programmed: ignore mode pin a
// - security cleared only in bootstrap after erase
// - init fast rate, receiver and transmitter on
// - start edge, centre check, mid samples, stop
// - E0 or C0 first: slow rate, rescale timeout
// - send break; zero first jumps to EEPROM
// - transmit pin is open drain only
// - RAM pointer starts at zero
// - variable length, ends after idle timeout
// - small RAM variant loads exactly 256 bytes
// - timeout 539 loops of 19 cycles
// - no timeout before first character
// - ones then silence jumps to RAM
// - store, echo, advance pointer per byte
// - preset pointers then jump to RAM
// - flags taken from mode pins at reset
// - expanded flag picks chip or expanded
`timescale 1ns/10ps
module sbla_top #(
    parameter int TMO_FAST_CYC = sbla_pkg::TMO_FAST,
    parameter int TMO_SLOW_CYC = sbla_pkg::TMO_SLOW,
    parameter bit SMALL_RAM = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mode_pin_a_i,
    input wire logic mode_pin_b_i,
    input wire logic security_disable_bit_i,
    input wire logic mem_erased_i,
    input wire logic vector_fetch_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic boot_rom_wr_i,
    input wire logic boot_rom_wdata_i,
    input wire logic rxd_i,
    output logic [15:0] bus_addr_o,
    output logic special_mode_flag_o,
    output logic expanded_mode_flag_o,
    output logic boot_rom_enable_o,
    output logic security_cleared_o,
    output logic port_open_drain_select_o,
    output logic txd_o,
    output logic txd_oe_o,
    output logic ram_we_o,
    output logic [15:0] ram_addr_o,
    output logic [7:0] ram_wdata_o,
    output logic jump_o,
    output logic [15:0] jump_addr_o,
    output logic [15:0] ptr_x_o,
    output logic [15:0] ptr_y_o,
    output logic slow_rate_o,
    output logic busy_o
);
    typedef enum logic [2:0] {
        SBLA_IDLE, SBLA_BREAK, SBLA_FIRST, SBLA_LOAD, SBLA_ECHO, SBLA_DONE
    } sbla_state_e;

    function automatic logic [15:0] sbla_bitlen(input logic slow);
        sbla_bitlen = slow ? 16'(sbla_pkg::BIT_SLOW)
                           : 16'(sbla_pkg::BIT_FAST);
    endfunction : sbla_bitlen

    // idle timeout reload, rescaled with the character time
    function automatic logic [24:0] sbla_tmo(input logic slow);
        sbla_tmo = slow ? 25'(TMO_SLOW_CYC)
                        : 25'(TMO_FAST_CYC);
    endfunction : sbla_tmo

    sbla_state_e state_r;
    logic init_r;
    logic rx_s1_r, rx_s2_r, rx_prev_r;
    logic [15:0] rx_cnt_r;
    logic [3:0] rx_bit_r;
    logic rx_busy_r;
    logic [7:0] rx_sh_r;
    logic rx_valid_r;
    logic [7:0] rx_data_r;
    logic tx_go;
    logic [8:0] tx_frame;
    logic [9:0] tx_sh_r;
    logic [3:0] tx_bit_r;
    logic [15:0] tx_cnt_r;
    logic tx_busy_r;
    logic [24:0] tmo_r;
    logic [15:0] ptr_r;
    logic [7:0] echo_r;
    logic [15:0] ram_end;
    logic tx_level;

    // security latch: set when the config bit says secured
    logic sec_r;

    // strap pins come from the board, bit 1 is pin b, bit 0 pin a
    logic [1:0] mode_s1_r;
    logic [1:0] mode_s2_r;

    // straps are async pins; no reset so they settle while reset is held
    always_ff @(posedge clk_i) begin
        mode_s1_r <= {mode_pin_b_i, mode_pin_a_i};
        mode_s2_r <= mode_s1_r;
    end

    // mode flags sampled while reset is held, applied at release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_r <= 1'b1;
            special_mode_flag_o <= 1'b0;
            expanded_mode_flag_o <= 1'b0;
            sec_r <= 1'b0;
        end else if (init_r) begin
            init_r <= 1'b0;
            special_mode_flag_o <= ~mode_s2_r[1];
            // secured part cannot reach expanded modes
            expanded_mode_flag_o <= security_disable_bit_i
                                    & mode_s2_r[0];
            sec_r <= ~security_disable_bit_i;
        end else if (sec_r && special_mode_flag_o && mem_erased_i) begin
            // erase proof is a level, so it may be held for many cycles
            sec_r <= 1'b0;
        end
    end

    // once cleared, only a fresh reset can secure the part again
    assign security_cleared_o = ~sec_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_rom_enable_o <= 1'b0;
        end else if (init_r) begin
            boot_rom_enable_o <= ~mode_s2_r[1]
                & ~(security_disable_bit_i & mode_s2_r[0]);
        end else if (!special_mode_flag_o) begin
            boot_rom_enable_o <= 1'b0;
        end else if (boot_rom_wr_i) begin
            boot_rom_enable_o <= boot_rom_wdata_i;
        end
    end

    always_comb begin
        bus_addr_o = cpu_addr_i;
        if (special_mode_flag_o && vector_fetch_i) begin
            bus_addr_o[sbla_pkg::VEC_ADDR_BIT] = 1'b0;
        end
    end

    // receiver, two-flop synchroniser first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_s1_r <= rxd_i;
            rx_s2_r <= rx_s1_r;
            rx_prev_r <= rx_s2_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_valid_r <= 1'b0;
            rx_data_r <= 8'h00;
        end else begin
            rx_valid_r <= 1'b0;
            if (state_r == SBLA_IDLE || state_r == SBLA_DONE) begin
                rx_busy_r <= 1'b0;
            end else if (!rx_busy_r) begin
                if (rx_prev_r && !rx_s2_r) begin
                    rx_busy_r <= 1'b1;
                    rx_bit_r <= 4'h0;
                    rx_cnt_r <= sbla_bitlen(slow_rate_o) >> 1;
                end
            end else if (rx_cnt_r != 16'h0000) begin
                rx_cnt_r <= rx_cnt_r - 16'h0001;
            end else begin
                rx_cnt_r <= sbla_bitlen(slow_rate_o) - 16'h0001;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0) begin
                    // false start rejected at centre
                    rx_busy_r <= ~rx_s2_r;
                end else if (rx_bit_r < 4'h9) begin
                    rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
                end else begin
                    rx_busy_r <= 1'b0;
                    // framing error drops the character
                    if (rx_s2_r) begin
                        rx_valid_r <= 1'b1;
                        rx_data_r <= rx_sh_r;
                    end
                end
            end
        end
    end

    // transmitter: break is a frame with data and stop low
    // only one frame is in flight; a new echo waits for the line
    assign tx_go = (state_r == SBLA_BREAK && !tx_busy_r)
                   || (state_r == SBLA_ECHO && !tx_busy_r);
    assign tx_frame = (state_r == SBLA_BREAK) ? 9'h000 : {1'b1, echo_r};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= 10'h3ff;
            tx_bit_r <= 4'h0;
            tx_cnt_r <= 16'h0000;
        end else if (tx_go) begin
            tx_busy_r <= 1'b1;
            tx_sh_r <= {tx_frame, 1'b0};
            tx_bit_r <= 4'(sbla_pkg::BREAK_BITS - 1);
            tx_cnt_r <= sbla_bitlen(slow_rate_o) - 16'h0001;
        end else if (tx_busy_r) begin
            if (tx_cnt_r != 16'h0000) begin
                tx_cnt_r <= tx_cnt_r - 16'h0001;
            end else if (tx_bit_r == 4'h0) begin
                tx_busy_r <= 1'b0;
                tx_sh_r <= 10'h3ff;
            end else begin
                tx_cnt_r <= sbla_bitlen(slow_rate_o) - 16'h0001;
                tx_bit_r <= tx_bit_r - 4'h1;
                tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            end
        end
    end
    assign tx_level = tx_sh_r[0];
    // open drain: only a low is driven, a pull-up gives the high
    assign txd_o = 1'b0;
    assign txd_oe_o = port_open_drain_select_o ? ~tx_level
                                               : 1'b0;

    assign ram_end = SMALL_RAM ? 16'(sbla_pkg::RAM_SMALL)
                               : 16'(sbla_pkg::RAM_BYTES);

    // download sequencer
    // idle: wait for boot rom mapping after the straps were taken
    // break: launch the break frame, then listen
    // first: lead character picks rate or the eeprom jump
    // load: wait for a byte or run down the idle timeout
    // echo: start the echo frame, store the byte, step the pointer
    // done: parked until the next reset
    // the small variant never times out, it only stops on a full ram
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= SBLA_IDLE;
            slow_rate_o <= 1'b0;
            port_open_drain_select_o <= 1'b0;
            ptr_r <= sbla_pkg::RAM_START;
            tmo_r <= 25'h0000000;
            echo_r <= 8'h00;
            jump_o <= 1'b0;
            jump_addr_o <= 16'h0000;
            ptr_x_o <= 16'h0000;
            ptr_y_o <= 16'h0000;
        end else begin
            jump_o <= 1'b0;
            case (state_r)
                SBLA_IDLE: begin
                    if (!init_r && boot_rom_enable_o) begin
                        slow_rate_o <= 1'b0;
                        port_open_drain_select_o <= 1'b1;
                        ptr_r <= sbla_pkg::RAM_START;
                        state_r <= SBLA_BREAK;
                    end
                end
                SBLA_BREAK: begin
                    if (tx_busy_r) begin
                        state_r <= SBLA_FIRST;
                    end
                end
                SBLA_FIRST: begin
                    // wait unbounded for the lead character
                    if (rx_valid_r) begin
                        tmo_r <= 25'(TMO_FAST_CYC);
                        state_r <= SBLA_LOAD;
                        if (rx_data_r == sbla_pkg::CHAR_ZERO) begin
                            jump_addr_o <= sbla_pkg::EEPROM_START;
                            jump_o <= 1'b1;
                            state_r <= SBLA_DONE;
                        end else if (rx_data_r == sbla_pkg::CHAR_E0 ||
                                     rx_data_r == sbla_pkg::CHAR_C0) begin
                            slow_rate_o <= 1'b1;
                            tmo_r <= 25'(TMO_SLOW_CYC);
                        end
                    end
                end
                SBLA_LOAD: begin
                    if (rx_valid_r) begin
                        echo_r <= rx_data_r;
                        state_r <= SBLA_ECHO;
                    end else if (tmo_r == 25'h0000000 && !SMALL_RAM) begin
                        ptr_x_o <= 16'h0000;
                        ptr_y_o <= ptr_r;
                        jump_addr_o <= sbla_pkg::RAM_START;
                        jump_o <= 1'b1;
                        state_r <= SBLA_DONE;
                    end else begin
                        tmo_r <= tmo_r - 25'h0000001;
                    end
                end
                SBLA_ECHO: begin
                    // leave only on the cycle that starts this echo, so
                    // a frame still running from the last byte is not
                    // mistaken for it
                    if (!tx_busy_r) begin
                        ptr_r <= ptr_r + 16'h0001;
                        tmo_r <= sbla_tmo(slow_rate_o);
                        state_r <= SBLA_LOAD;
                        if (ptr_r + 16'h0001 == ram_end) begin
                            ptr_x_o <= 16'h0000;
                            ptr_y_o <= ptr_r + 16'h0001;
                            jump_addr_o <= sbla_pkg::RAM_START;
                            jump_o <= 1'b1;
                            state_r <= SBLA_DONE;
                        end
                    end
                end
                SBLA_DONE: begin
                    state_r <= SBLA_DONE;
                end
                default: begin
                    state_r <= SBLA_IDLE;
                end
            endcase
        end
    end


    // store strobe shares the cycle with the echo start
    assign ram_we_o = (state_r == SBLA_ECHO) && !tx_busy_r;
    assign ram_addr_o = ptr_r;
    assign ram_wdata_o = echo_r;
    assign busy_o = (state_r != SBLA_IDLE) && (state_r != SBLA_DONE);
endmodule : sbla_top

// [bench/sbla_assertions.sv]
// port checker for the bootloader mode logic and sequencer
`timescale 1ns/10ps
module sbla_checker #(
    parameter int TMO_FAST_CYC = 1,
    parameter int TMO_SLOW_CYC = 1,
    parameter bit SMALL_RAM = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mode_pin_b_i,
    input wire logic security_disable_bit_i,
    input wire logic mem_erased_i,
    input wire logic vector_fetch_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic boot_rom_wr_i,
    input wire logic boot_rom_wdata_i,
    input wire logic [15:0] bus_addr_o,
    input wire logic special_mode_flag_o,
    input wire logic expanded_mode_flag_o,
    input wire logic boot_rom_enable_o,
    input wire logic security_cleared_o,
    input wire logic txd_o,
    input wire logic ram_we_o,
    input wire logic jump_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_vec; vector_fetch_i && special_mode_flag_o |->
        bus_addr_o == {cpu_addr_i[15], 1'b0, cpu_addr_i[13:0]}; endproperty
    a_vec: assert property (p_vec) else $error("vector bit 14 not low");
    property p_flag; $fell(rst_i) |=>
        special_mode_flag_o == !$past(mode_pin_b_i); endproperty
    a_flag: assert property (p_flag) else $error("special flag wrong");
    property p_sec; $fell(rst_i) && !security_disable_bit_i |=>
        !expanded_mode_flag_o; endproperty
    a_sec: assert property (p_sec) else $error("pin a not ignored");
    property p_boot; $fell(rst_i) |=>
        boot_rom_enable_o == (special_mode_flag_o && !expanded_mode_flag_o);
    endproperty
    a_boot: assert property (p_boot) else $error("boot rom reset wrong");
    property p_wr; boot_rom_wr_i && special_mode_flag_o |=>
        boot_rom_enable_o == $past(boot_rom_wdata_i); endproperty
    a_wr: assert property (p_wr) else $error("boot rom write lost");
    property p_clr; $rose(security_cleared_o) && !$past(rst_i, 2) |->
        $past(special_mode_flag_o) && $past(mem_erased_i); endproperty
    a_clr: assert property (p_clr) else $error("security cleared");
    property p_od; txd_o == 1'b0; endproperty
    a_od: assert property (p_od) else $error("transmit drove high");
    property p_we; ram_we_o |=> !ram_we_o; endproperty
    a_we: assert property (p_we) else $error("store not one cycle");
    property p_jmp; jump_o |=> (!jump_o) [*8]; endproperty
    a_jmp: assert property (p_jmp) else $error("jump repeated");
endmodule : sbla_checker
bind sbla_top sbla_checker #(.TMO_FAST_CYC(TMO_FAST_CYC),
    .TMO_SLOW_CYC(TMO_SLOW_CYC), .SMALL_RAM(SMALL_RAM)) u_sbla_checker (
    .clk_i(clk_i), .rst_i(rst_i), .mode_pin_b_i(mode_pin_b_i),
    .security_disable_bit_i(security_disable_bit_i),
    .mem_erased_i(mem_erased_i), .vector_fetch_i(vector_fetch_i),
    .cpu_addr_i(cpu_addr_i), .boot_rom_wr_i(boot_rom_wr_i),
    .boot_rom_wdata_i(boot_rom_wdata_i), .bus_addr_o(bus_addr_o),
    .special_mode_flag_o(special_mode_flag_o),
    .expanded_mode_flag_o(expanded_mode_flag_o),
    .boot_rom_enable_o(boot_rom_enable_o),
    .security_cleared_o(security_cleared_o), .txd_o(txd_o),
    .ram_we_o(ram_we_o), .jump_o(jump_o));

// [bench/sbla_host.sv]
// host serial model: sends 8N1 frames and reads echoes
`timescale 1ns/10ps
module sbla_host (
    input wire logic clk_i,
    input wire logic line_i,
    output logic rxd_o
);
    initial rxd_o = 1'b1;
    task automatic send(input logic [7:0] b, input int bc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o <= f[i];
            repeat (bc) @(posedge clk_i);
        end
    endtask : send
    // ok is the stop sample, so a break reads as 00 with ok low
    task automatic recv(input int bc, output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (line_i === 1'b1 && n < 100000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (bc / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bc) @(posedge clk_i);
            b[i] = line_i;
        end
        repeat (bc) @(posedge clk_i);
        ok = line_i;
    endtask : recv
endmodule : sbla_host

// [bench/test_sbla_top.sv]
// self-checking bench for the serial bootloader
`timescale 1ns/10ps
module test_sbla_top;
    localparam int TMO = 40000;
    localparam int BC = sbla_pkg::BIT_FAST;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic mode_pin_a_i = 1'b0;
    logic mode_pin_b_i = 1'b0;
    logic security_disable_bit_i = 1'b1;
    logic mem_erased_i = 1'b0;
    logic vector_fetch_i = 1'b0;
    logic [15:0] cpu_addr_i = 16'h0000;
    logic boot_rom_wr_i = 1'b0;
    logic boot_rom_wdata_i = 1'b0;
    logic rxd_i, special_mode_flag_o, expanded_mode_flag_o, txd_o, txd_oe_o;
    logic boot_rom_enable_o, security_cleared_o, port_open_drain_select_o;
    logic ram_we_o, jump_o, slow_rate_o, busy_o, line;
    logic we_seen = 1'b0;
    logic [15:0] bus_addr_o, ram_addr_o, jump_addr_o, ptr_x_o, ptr_y_o;
    logic [15:0] we_addr;
    logic [7:0] ram_wdata_o, we_data;
    int fails = 0;
    int n_compared = 0;
    assign line = ~txd_oe_o; // pull-up holds the line high
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            we_seen <= 1'b0;
        end else if (ram_we_o) begin
            we_seen <= 1'b1;
            we_addr <= ram_addr_o;
            we_data <= ram_wdata_o;
        end
    end
    sbla_top #(.TMO_FAST_CYC(TMO), .TMO_SLOW_CYC(TMO * 7),
        .SMALL_RAM(1'b0)) u_sbla_top (
        .clk_i(clk_i), .rst_i(rst_i), .mode_pin_a_i(mode_pin_a_i),
        .mode_pin_b_i(mode_pin_b_i), .mem_erased_i(mem_erased_i),
        .security_disable_bit_i(security_disable_bit_i),
        .vector_fetch_i(vector_fetch_i), .cpu_addr_i(cpu_addr_i),
        .boot_rom_wr_i(boot_rom_wr_i), .boot_rom_wdata_i(boot_rom_wdata_i),
        .rxd_i(rxd_i), .bus_addr_o(bus_addr_o),
        .special_mode_flag_o(special_mode_flag_o),
        .expanded_mode_flag_o(expanded_mode_flag_o),
        .boot_rom_enable_o(boot_rom_enable_o),
        .security_cleared_o(security_cleared_o),
        .port_open_drain_select_o(port_open_drain_select_o),
        .txd_o(txd_o), .txd_oe_o(txd_oe_o), .ram_we_o(ram_we_o),
        .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o), .jump_o(jump_o),
        .jump_addr_o(jump_addr_o), .ptr_x_o(ptr_x_o), .ptr_y_o(ptr_y_o),
        .slow_rate_o(slow_rate_o), .busy_o(busy_o));
    sbla_host u_sbla_host (.clk_i(clk_i), .line_i(line), .rxd_o(rxd_i));
    task automatic complete_run();
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic do_reset(input logic b, input logic a, input logic ns);
        @(posedge clk_i);
        rst_i <= 1'b1;
        mode_pin_b_i <= b;
        mode_pin_a_i <= a;
        security_disable_bit_i <= ns;
        mem_erased_i <= 1'b0;
        vector_fetch_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask : do_reset
    task automatic wait_jump(input int lim, input logic [15:0] exp);
        int n;
        n = 0;
        while (jump_o !== 1'b1 && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= lim) begin
            fails++;
            complete_run();
        end
        check("jump_addr", jump_addr_o, exp);
    endtask : wait_jump
    // every strap and security combination, then privileged writes
    task automatic test_modes();
        logic ea;
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2], i[1], i[0]);
            ea = i[0] & i[1];
            check("special", special_mode_flag_o, !i[2]);
            check("expanded", expanded_mode_flag_o, ea);
            check("boot_rom", boot_rom_enable_o, !i[2] & !ea);
            check("secured", security_cleared_o, i[0]);
            @(posedge clk_i);
            cpu_addr_i <= 16'hffff;
            vector_fetch_i <= 1'b1;
            boot_rom_wr_i <= 1'b1;
            boot_rom_wdata_i <= 1'b1;
            mem_erased_i <= 1'b1;
            @(posedge clk_i);
            boot_rom_wr_i <= 1'b0;
            repeat (2) @(negedge clk_i);
            check("vector", bus_addr_o, i[2] ? 16'hffff : 16'hbfff);
            check("boot_wr", boot_rom_enable_o, !i[2]);
            check("erased", security_cleared_o, i[0] | !i[2]);
        end
    endtask : test_modes
    task automatic test_eeprom();
        int n;
        do_reset(1'b0, 1'b0, 1'b1);
        n = 0;
        while (txd_oe_o !== 1'b1 && n < 1000) begin
            @(negedge clk_i);
            n++;
        end
        check("break", txd_oe_o, 1'b1);
        check("odrain", port_open_drain_select_o, 1'b1);
        @(posedge clk_i);
        fork
            u_sbla_host.send(8'h00, BC);
            wait_jump(12 * BC, 16'hb600);
        join
    endtask : test_eeprom
    task automatic test_download();
        logic [7:0] b;
        logic ok;
        do_reset(1'b0, 1'b0, 1'b1);
        u_sbla_host.recv(BC, b, ok);
        check("break_data", b, 8'h00);
        check("break_stop", ok, 1'b0);
        repeat (BC) @(posedge clk_i);
        u_sbla_host.send(8'hff, BC);
        fork
            u_sbla_host.send(8'ha5, BC);
            u_sbla_host.recv(BC, b, ok);
        join
        check("echo", b, 8'ha5);
        check("echo_stop", ok, 1'b1);
        check("ram_we", we_seen, 1'b1);
        check("ram_addr", we_addr, 16'h0000);
        check("ram_data", we_data, 8'ha5);
        check("slow", slow_rate_o, 1'b0);
        wait_jump(2 * TMO, 16'h0000);
        check("ptr_y", ptr_y_o, 16'h0001);
        check("ptr_x", ptr_x_o, 16'h0000);
        check("busy_end", busy_o, 1'b0);
    endtask : test_download
    // a lead character seen as e0 selects the slow rate
    task automatic test_slow();
        do_reset(1'b0, 1'b0, 1'b1);
        repeat (BC) @(posedge clk_i);
        u_sbla_host.send(8'he0, BC);
        @(negedge clk_i);
        check("slow_sel", slow_rate_o, 1'b1);
        check("busy_load", busy_o, 1'b1);
        check("jump_none", jump_o, 1'b0);
    endtask : test_slow
    initial begin
        test_modes();
        test_eeprom();
        test_download();
        test_slow();
        complete_run();
    end
endmodule : test_sbla_top
